// File: include/lsu_consts.vh
// Constants for the load/store unit and its I/O merge path
`ifndef LSU_CONSTS_VH
`define LSU_CONSTS_VH

// Address layout
`define PA_W            44
`define VA_W            48
`define IO_BIT          43
`define BLK_LO          6
`define BLK_W           38
`define IDX_LO          6
`define IDX_W           9

// Access sizes
`define SZ_BYTE         2'h0
`define SZ_WORD         2'h1
`define SZ_LW           2'h2
`define SZ_QW           2'h3

// Queue depths and stall thresholds
`define LQ_DEPTH        8
`define SQ_DEPTH        8
`define MAF_DEPTH       8
`define Q_STALL_AT      4'h4
`define MAF_MIN_FREE    4'h4

// Offchip request FIFO: store flag, address, size, byte mask, data
`define REQ_W           623
`define FIFO_DEPTH      32
`define FIFO_AW         5

// Merge window inactivity time in cycles
`define IO_IDLE_CYCLES  1024
`define IDLE_W          11

`endif

// File: verilog/io_req_fifo.v
// Request FIFO between the merge registers and the offchip port
`timescale 1ns/1ps

module io_req_fifo #(
    parameter W     = 8,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst,
    // Filling side
    input  wire         in_valid,
    input  wire [W-1:0] in_data,
    output wire         in_ready,
    // Draining side
    output wire         out_valid,
    output wire [W-1:0] out_data,
    input  wire         out_ready
);

reg [W-1:0] mem [0:DEPTH-1];
reg [AW:0]  wr_ptr;
reg [AW:0]  rd_ptr;

wire full  = (wr_ptr == {~rd_ptr[AW], rd_ptr[AW-1:0]});
wire empty = (wr_ptr == rd_ptr);

assign in_ready  = !full;
assign out_valid = !empty;
assign out_data  = mem[rd_ptr[AW-1:0]];

always @(posedge clk) begin
    if (rst) begin
        wr_ptr <= {(AW+1){1'b0}};
        rd_ptr <= {(AW+1){1'b0}};
    end else begin
        if (in_valid && !full) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
            wr_ptr              <= wr_ptr + 1'b1;
        end
        if (out_ready && !empty)
            rd_ptr <= rd_ptr + 1'b1;
    end
end

endmodule // io_req_fifo

// File: verilog/io_merge_reg.v
// Merge register that gathers ascending I/O accesses into one block
`timescale 1ns/1ps
`include "lsu_consts.vh"

module io_merge_reg (
    // Clock and reset
    input  wire         clk,
    input  wire         rst,
    // Replayed accesses
    input  wire         in_valid,
    input  wire [43:0]  in_addr,
    input  wire [1:0]   in_size,
    input  wire [63:0]  in_data,
    output wire         in_ready,
    // Window control
    input  wire         close,
    input  wire         limit32,
    // Merged block out
    output reg          out_valid,
    output reg  [43:0]  out_addr,
    output reg  [1:0]   out_size,
    output reg  [63:0]  out_mask,
    output reg  [511:0] out_data,
    input  wire         out_ready
);

reg         open;
reg         closing;
reg [43:0]  base;
reg [1:0]   size;
reg [63:0]  mask;
reg [511:0] data;
reg [6:0]   tail_end;

wire [5:0]   off   = in_addr[5:0];
wire [6:0]   nbyte = 7'h1 << in_size;
wire [63:0]  bmask = ((64'h1 << nbyte) - 64'h1) << off;
wire [511:0] sdata = {448'h0, in_data} << {off, 3'h0};
wire [511:0] bitm;
wire         same32 = (in_addr[43:5] == base[43:5]);
wire         same64 = (in_addr[43:6] == base[43:6]);
// Quadwords may be held to 32-byte blocks
wire         fits = (in_size == `SZ_LW || limit32) ? same32 : same64;
// Only like-sized longwords or quadwords, ascending, without overlap
wire         can_merge = open && !closing && !close && in_size == size && in_size[1]
                         && fits && {1'b0, off} >= tail_end;
wire         out_free = !out_valid || out_ready;
wire         emit = open && out_free && (closing || close || (in_valid && !can_merge));

assign in_ready = can_merge || !open || out_free;

genvar g;
generate
    for (g = 0; g < 64; g = g + 1) begin : g_bits
        assign bitm[g*8 +: 8] = {8{bmask[g]}};
    end
endgenerate

always @(posedge clk) begin
    if (rst) begin
        open      <= 1'b0;
        closing   <= 1'b0;
        out_valid <= 1'b0;
    end else begin
        if (out_valid && out_ready)
            out_valid <= 1'b0;
        if (emit || !open)
            closing <= 1'b0;
        else if (close)
            closing <= 1'b1;
        if (emit) begin
            out_valid <= 1'b1;
            out_addr  <= base;
            out_size  <= size;
            out_mask  <= mask;
            out_data  <= data;
            open      <= 1'b0;
        end
        if (in_valid && in_ready) begin
            if (can_merge) begin
                mask <= mask | bmask;
                data <= (data & ~bitm) | sdata;
            end else begin
                open <= 1'b1;
                base <= in_addr;
                size <= in_size;
                mask <= bmask;
                data <= sdata;
            end
            tail_end <= {1'b0, off} + nbyte;
        end
    end
end

endmodule // io_merge_reg

// File: verilog/lsu_io_merge.v
// Load/store unit: queues, miss posting, store drain and I/O merge path
`timescale 1ns/1ps
`include "lsu_consts.vh"

// Overview of operation
// [R1] Physical address bit 43 clear is memory space, set is I/O space.
// [R2] Up to two loads or stores arrive per cycle with 48-bit virtual addresses.
// [R3] Memory loads translate and index cache together, then enter the load queue.
// [R4] A memory load hit writes formatted data to its integer or float register.
// [R5] Load misses post a block to the miss file; same-block misses are dropped.
// [R6] Returned fill data completes every waiting load of that block.
// [R7] I/O loads wait for retirement, then replay in order, one per cycle.
// [R8] I/O loads merge only as ascending longwords in 32 or quadwords in 64 bytes.
// [R9] The 32-byte limit setting confines quadword merging to 32-byte blocks.
// [R10] Barriers, I/O loads or 1024 idle store cycles close the merge window.
// [R11] Merged I/O reads leave in the order they were delivered.
// [R12] Stores translate, probe the cache and record address, data and outcome.
// [R13] Store misses post the block; clean hits post an ownership upgrade.
// [R14] Retired stores to dirty unshared blocks become writable in order, two per cycle.
// [R15] Writable entries drain into the cache in order, two per cycle.
// [R16] Blocks of writable entries are locked against system probes.
// [R17] Loads matching a pending store's cache index take the store's data.
// [R18] Retired I/O stores replay into the write buffer in order, one per cycle.
// [R19] Queued I/O stores never forward data to loads.
// [R20] I/O stores merge like I/O loads: like-sized, ascending, aligned blocks.
// [R21] Merged I/O writes leave in the order they arrived.
// [R22] The idle timer restarts on each accepted I/O store and on every close.
module lsu_io_merge #(
    parameter IDLE_CYCLES = `IO_IDLE_CYCLES
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst,
    // Issue, two slots
    input  wire [1:0]   iss_valid,
    input  wire [1:0]   iss_store,
    input  wire [95:0]  iss_va,
    input  wire [3:0]   iss_size,
    input  wire [127:0] iss_data,
    input  wire [13:0]  iss_dest,
    output reg          iss_stall,
    // Translation and cache probe results
    input  wire [87:0]  dtb_pa,
    input  wire [1:0]   dc_hit,
    input  wire [1:0]   dc_dirty,
    input  wire [1:0]   dc_shared,
    input  wire [127:0] dc_rdata,
    // Register writes
    output reg  [1:0]   reg_wr_valid,
    output reg  [13:0]  reg_wr_dest,
    output reg  [127:0] reg_wr_data,
    // Retirement, barriers and configuration
    input  wire         ld_retire,
    input  wire         st_retire,
    input  wire         memory_barrier,
    input  wire         write_barrier,
    input  wire         io_merge_32b_limit,
    // Miss address file
    output reg  [1:0]   maf_req_valid,
    output reg  [1:0]   maf_req_upgrade,
    output reg  [75:0]  maf_req_block,
    input  wire         fill_valid,
    input  wire [37:0]  fill_block,
    output reg  [7:0]   ld_done,
    output reg  [55:0]  ld_done_dest,
    input  wire         own_valid,
    input  wire [37:0]  own_block,
    // Data cache writes and probe lock
    output reg  [1:0]   dc_wr_valid,
    output reg  [87:0]  dc_wr_pa,
    output reg  [3:0]   dc_wr_size,
    output reg  [127:0] dc_wr_data,
    input  wire [37:0]  probe_block,
    output reg          probe_locked,
    // Offchip I/O requests
    output reg          io_req_valid,
    output reg          io_req_store,
    output reg  [43:0]  io_req_addr,
    output reg  [1:0]   io_req_size,
    output reg  [63:0]  io_req_mask,
    output reg  [511:0] io_req_data,
    input  wire         io_req_ready
);

localparam LQ = `LQ_DEPTH;
localparam SQ = `SQ_DEPTH;
localparam MF = `MAF_DEPTH;

function [63:0] fmt;
    input [63:0] d;
    input [1:0]  sz;
    begin
        case (sz)
            `SZ_BYTE: fmt = {56'h0, d[7:0]};
            `SZ_WORD: fmt = {48'h0, d[15:0]};
            `SZ_LW:   fmt = {32'h0, d[31:0]};
            default:  fmt = d;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// State

reg [LQ-1:0] lq_v;
reg [LQ-1:0] lq_io;
reg [LQ-1:0] lq_wait;
reg [LQ-1:0] lq_ret;
reg [43:0]   lq_pa [0:LQ-1];
reg [1:0]    lq_size [0:LQ-1];
reg [6:0]    lq_dest [0:LQ-1];
reg [3:0]    lq_head;
reg [3:0]    lq_tail;
reg [3:0]    lq_rp;

reg [SQ-1:0] sq_v;
reg [SQ-1:0] sq_io;
reg [SQ-1:0] sq_dirty;
reg [SQ-1:0] sq_shr;
reg [SQ-1:0] sq_ret;
reg [SQ-1:0] sq_wr;
reg [43:0]   sq_pa [0:SQ-1];
reg [63:0]   sq_data [0:SQ-1];
reg [1:0]    sq_size [0:SQ-1];
reg [8:0]    sq_idx [0:SQ-1];
reg [3:0]    sq_head;
reg [3:0]    sq_tail;
reg [3:0]    sq_rp;
reg [3:0]    sq_wp;

reg [MF-1:0] maf_v;
reg [37:0]   maf_blk [0:MF-1];

reg [`IDLE_W-1:0] idle_cnt;

////////////////////////////////////////////////////////////////////////////////
// Issue decode, forwarding and miss posting

reg [1:0]   io;
reg [1:0]   fwd;
reg [1:0]   req;
reg [1:0]   upg;
reg [1:0]   drop;
reg [127:0] fwd_data;
reg [2:0]   f0;
reg [2:0]   f1;
reg [3:0]   nfree;
integer     s;
integer     j;

wire [1:0] is_ld = iss_valid & ~iss_store;
wire [1:0] is_st = iss_valid & iss_store;

always @* begin
    io       = 2'h0;
    fwd      = 2'h0;
    req      = 2'h0;
    upg      = 2'h0;
    drop     = 2'h0;
    fwd_data = 128'h0;
    f0       = 3'h0;
    f1       = 3'h0;
    nfree    = 4'h0;
    for (s = 0; s < 2; s = s + 1) begin
        // [R1] space from top bit
        io[s] = dtb_pa[s*44+`IO_BIT];
        for (j = 0; j < SQ; j = j + 1) begin
            // [R17] [R19] index match, memory stores only
            if (sq_v[j] && !sq_io[j] && sq_idx[j] == iss_va[s*48+`IDX_LO +: `IDX_W]) begin
                fwd[s]              = 1'b1;
                fwd_data[s*64 +: 64] = sq_data[j];
            end
        end
        // [R5] [R13] miss or upgrade posting
        req[s] = iss_valid[s] && !io[s] && !dc_hit[s] && (iss_store[s] || !fwd[s]);
        upg[s] = is_st[s] && !io[s] && dc_hit[s] && (!dc_dirty[s] || dc_shared[s]);
        for (j = 0; j < MF; j = j + 1) begin
            // [R5] same block already held
            if (maf_v[j] && maf_blk[j] == dtb_pa[s*44+`BLK_LO +: `BLK_W])
                drop[s] = 1'b1;
        end
    end
    if ((req[0] || upg[0]) && dtb_pa[43:6] == dtb_pa[87:50])
        drop[1] = 1'b1;
    for (j = MF - 1; j >= 0; j = j - 1) begin
        if (!maf_v[j]) begin
            f1    = f0;
            f0    = j[2:0];
            nfree = nfree + 4'h1;
        end
    end
end

wire [1:0] mpost = (req | upg) & ~drop;
wire [2:0] ma1   = mpost[0] ? f1 : f0;
wire [2:0] la [0:1];
wire [2:0] sa [0:1];
assign la[0] = lq_tail[2:0];
assign la[1] = lq_tail[2:0] + {2'h0, is_ld[0]};
assign sa[0] = sq_tail[2:0];
assign sa[1] = sq_tail[2:0] + {2'h0, is_st[0]};

////////////////////////////////////////////////////////////////////////////////
// Load queue

wire [2:0] lh       = lq_head[2:0];
wire       lm_valid = lq_v[lh] && lq_ret[lh] && lq_io[lh];
wire       lm_ready;
wire       lq_free  = lq_v[lh] && lq_ret[lh] && !lq_wait[lh] && (!lq_io[lh] || lm_ready);

always @(posedge clk) begin
    if (rst) begin
        lq_v         <= {LQ{1'b0}};
        lq_wait      <= {LQ{1'b0}};
        lq_ret       <= {LQ{1'b0}};
        lq_head      <= 4'h0;
        lq_tail      <= 4'h0;
        lq_rp        <= 4'h0;
        {ld_done, ld_done_dest, reg_wr_valid, reg_wr_dest, reg_wr_data} <= 208'h0;
    end else begin
        for (j = 0; j < LQ; j = j + 1) begin
            ld_done_dest[j*7 +: 7] <= lq_dest[j];
            // [R6] fill completes waiting loads
            ld_done[j] <= fill_valid && lq_wait[j] && lq_pa[j][43:6] == fill_block;
            if (fill_valid && lq_wait[j] && lq_pa[j][43:6] == fill_block)
                lq_wait[j] <= 1'b0;
        end
        // [R7] retired I/O load leaves head in order
        if (lq_free) begin
            lq_v[lh]   <= 1'b0;
            lq_ret[lh] <= 1'b0;
            lq_head    <= lq_head + 4'h1;
        end
        if (ld_retire) begin
            lq_ret[lq_rp[2:0]] <= 1'b1;
            lq_rp              <= lq_rp + 4'h1;
        end
        for (s = 0; s < 2; s = s + 1) begin
            // [R3] record address, destination and format
            if (is_ld[s]) begin
                lq_v[la[s]]    <= 1'b1;
                lq_io[la[s]]   <= io[s];
                lq_wait[la[s]] <= !io[s] && !dc_hit[s] && !fwd[s];
                lq_ret[la[s]]  <= 1'b0;
                lq_pa[la[s]]   <= dtb_pa[s*44 +: 44];
                lq_size[la[s]] <= iss_size[s*2 +: 2];
                lq_dest[la[s]] <= iss_dest[s*7 +: 7];
            end
            // [R4] hit or forwarded data to register
            reg_wr_valid[s]        <= is_ld[s] && !io[s] && (fwd[s] || dc_hit[s]);
            reg_wr_dest[s*7 +: 7]  <= iss_dest[s*7 +: 7];
            reg_wr_data[s*64 +: 64] <= fmt(fwd[s] ? fwd_data[s*64 +: 64] : dc_rdata[s*64 +: 64],
                                          iss_size[s*2 +: 2]);
        end
        // [R2] two accesses per cycle
        lq_tail <= lq_tail + {3'h0, is_ld[0]} + {3'h0, is_ld[1]};
    end
end

////////////////////////////////////////////////////////////////////////////////
// Store queue, writable marking and drain

wire [2:0] w0  = sq_wp[2:0];
wire [2:0] w1  = w0 + 3'h1;
wire       wk0 = sq_wp != sq_tail && sq_v[w0] && sq_ret[w0]
                 && (sq_io[w0] || (sq_dirty[w0] && !sq_shr[w0]));
wire       wk1 = wk0 && sq_wp + 4'h1 != sq_tail && sq_v[w1] && sq_ret[w1]
                 && (sq_io[w1] || (sq_dirty[w1] && !sq_shr[w1]));
wire [2:0] h0  = sq_head[2:0];
wire [2:0] h1  = h0 + 3'h1;
wire       d0  = sq_v[h0] && sq_wr[h0];
wire       d1  = d0 && sq_wr[h1];
wire       sm_valid = sq_v[h0] && sq_io[h0] && sq_ret[h0] && sq_wp != sq_head;
wire       sm_ready;
wire       sm_take = sm_valid && sm_ready;

always @(posedge clk) begin
    if (rst) begin
        sq_v         <= {SQ{1'b0}};
        sq_ret       <= {SQ{1'b0}};
        sq_wr        <= {SQ{1'b0}};
        sq_head      <= 4'h0;
        sq_tail      <= 4'h0;
        sq_rp        <= 4'h0;
        sq_wp        <= 4'h0;
        {dc_wr_valid, dc_wr_pa, dc_wr_size, dc_wr_data} <= 222'h0;
        probe_locked <= 1'b0;
    end else begin
        probe_locked <= 1'b0;
        for (j = 0; j < SQ; j = j + 1) begin
            if (own_valid && sq_pa[j][43:6] == own_block) begin
                sq_dirty[j] <= 1'b1;
                sq_shr[j]   <= 1'b0;
            end
            // [R16] lock blocks of writable entries
            if (sq_wr[j] && sq_pa[j][43:6] == probe_block)
                probe_locked <= 1'b1;
        end
        if (st_retire) begin
            sq_ret[sq_rp[2:0]] <= 1'b1;
            sq_rp              <= sq_rp + 4'h1;
        end
        // [R14] writable in order, two per cycle
        if (wk0 && !sq_io[w0])
            sq_wr[w0] <= 1'b1;
        if (wk1 && !sq_io[w1])
            sq_wr[w1] <= 1'b1;
        sq_wp <= sq_wp + {3'h0, wk0} + {3'h0, wk1};
        // [R15] drain to cache in order, two per cycle
        dc_wr_valid <= {d1, d0};
        dc_wr_pa    <= {sq_pa[h1], sq_pa[h0]};
        dc_wr_size  <= {sq_size[h1], sq_size[h0]};
        dc_wr_data  <= {sq_data[h1], sq_data[h0]};
        // [R18] one retired I/O store per cycle
        if (d0 || sm_take) begin
            sq_v[h0]   <= 1'b0;
            sq_wr[h0]  <= 1'b0;
            sq_ret[h0] <= 1'b0;
        end
        if (d1) begin
            sq_v[h1]   <= 1'b0;
            sq_wr[h1]  <= 1'b0;
            sq_ret[h1] <= 1'b0;
        end
        sq_head <= sq_head + {3'h0, d0} + {3'h0, d1} + {3'h0, sm_take};
        for (s = 0; s < 2; s = s + 1) begin
            // [R12] record address, data and probe outcome
            if (is_st[s]) begin
                sq_v[sa[s]]     <= 1'b1;
                sq_io[sa[s]]    <= io[s];
                sq_ret[sa[s]]   <= 1'b0;
                sq_wr[sa[s]]    <= 1'b0;
                sq_dirty[sa[s]] <= dc_hit[s] && dc_dirty[s];
                sq_shr[sa[s]]   <= dc_shared[s];
                sq_pa[sa[s]]    <= dtb_pa[s*44 +: 44];
                sq_data[sa[s]]  <= iss_data[s*64 +: 64];
                sq_size[sa[s]]  <= iss_size[s*2 +: 2];
                sq_idx[sa[s]]   <= iss_va[s*48+`IDX_LO +: `IDX_W];
            end
        end
        sq_tail <= sq_tail + {3'h0, is_st[0]} + {3'h0, is_st[1]};
    end
end

////////////////////////////////////////////////////////////////////////////////
// Miss address file and issue stall

always @(posedge clk) begin
    if (rst) begin
        maf_v           <= {MF{1'b0}};
        {maf_req_valid, maf_req_upgrade, maf_req_block} <= 80'h0;
        iss_stall       <= 1'b0;
    end else begin
        for (j = 0; j < MF; j = j + 1) begin
            if ((fill_valid && maf_blk[j] == fill_block)
                || (own_valid && maf_blk[j] == own_block))
                maf_v[j] <= 1'b0;
        end
        // [R5] [R13] allocate only new blocks
        if (mpost[0]) begin
            maf_v[f0]   <= 1'b1;
            maf_blk[f0] <= dtb_pa[43:6];
        end
        if (mpost[1]) begin
            maf_v[ma1]   <= 1'b1;
            maf_blk[ma1] <= dtb_pa[87:50];
        end
        maf_req_valid   <= mpost;
        maf_req_upgrade <= upg;
        maf_req_block   <= {dtb_pa[87:50], dtb_pa[43:6]};
        iss_stall <= (lq_tail - lq_head >= `Q_STALL_AT) || (sq_tail - sq_head >= `Q_STALL_AT)
                     || nfree < `MAF_MIN_FREE;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Merge window control and offchip path

wire [31:0] idle_lim = IDLE_CYCLES - 1;
wire        idle_hit = (idle_cnt == idle_lim[`IDLE_W-1:0]);
// [R10] barriers, I/O loads and idle timer close the window
wire        close = memory_barrier || write_barrier || (|(is_ld & io)) || idle_hit;

// [R22] restart on store accept or close
always @(posedge clk) begin
    if (rst || sm_take || close)
        idle_cnt <= {`IDLE_W{1'b0}};
    else
        idle_cnt <= idle_cnt + 1'b1;
end

wire         so_v;
wire         lo_v;
wire [43:0]  so_a;
wire [43:0]  lo_a;
wire [1:0]   so_s;
wire [1:0]   lo_s;
wire [63:0]  so_m;
wire [63:0]  lo_m;
wire [511:0] so_d;
wire [511:0] lo_d;
wire         fi_ready;
wire         fo_valid;
wire [`REQ_W-1:0] fo_data;
wire         fo_ready = !io_req_valid || io_req_ready;

// [R8] [R9] load merge register
io_merge_reg u_ld_merge (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (lm_valid),
    .in_addr   (lq_pa[lh]),
    .in_size   (lq_size[lh]),
    .in_data   (64'h0),
    .in_ready  (lm_ready),
    .close     (close),
    .limit32   (io_merge_32b_limit),
    .out_valid (lo_v),
    .out_addr  (lo_a),
    .out_size  (lo_s),
    .out_mask  (lo_m),
    .out_data  (lo_d),
    .out_ready (fi_ready && !so_v)
);

// [R20] [R9] store merge register
io_merge_reg u_st_merge (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (sm_valid),
    .in_addr   (sq_pa[h0]),
    .in_size   (sq_size[h0]),
    .in_data   (sq_data[h0]),
    .in_ready  (sm_ready),
    .close     (close),
    .limit32   (io_merge_32b_limit),
    .out_valid (so_v),
    .out_addr  (so_a),
    .out_size  (so_s),
    .out_mask  (so_m),
    .out_data  (so_d),
    .out_ready (fi_ready)
);

// [R11] [R21] closed blocks leave in arrival order
io_req_fifo #(
    .W     (`REQ_W),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (so_v || lo_v),
    .in_data   (so_v ? {1'b1, so_a, so_s, so_m, so_d} : {1'b0, lo_a, lo_s, lo_m, lo_d}),
    .in_ready  (fi_ready),
    .out_valid (fo_valid),
    .out_data  (fo_data),
    .out_ready (fo_ready)
);

always @(posedge clk) begin
    if (rst) begin
        io_req_valid <= 1'b0;
        {io_req_store, io_req_addr, io_req_size, io_req_mask, io_req_data} <= {`REQ_W{1'b0}};
    end else if (fo_ready) begin
        io_req_valid <= fo_valid;
        {io_req_store, io_req_addr, io_req_size, io_req_mask, io_req_data} <= fo_data;
    end
end

endmodule // lsu_io_merge

// File: verif/lsu_io_merge_sva.sv
// Port assertions for the load/store unit
`timescale 1ns/1ps
module lsu_io_merge_sva (
    // Clock and reset
    input logic        clk,
    input logic        rst,
    // Issue side
    input logic [1:0]  iss_valid,
    input logic [1:0]  iss_store,
    input logic        iss_stall,
    input logic [87:0] dtb_pa,
    input logic [1:0]  dc_hit,
    input logic        fill_valid,
    input logic        io_merge_32b_limit,
    // Answers
    input logic [1:0]  reg_wr_valid,
    input logic [1:0]  maf_req_valid,
    input logic [7:0]  ld_done,
    input logic [1:0]  dc_wr_valid,
    // Offchip
    input logic        io_req_valid,
    input logic        io_req_ready,
    input logic [1:0]  io_req_size,
    input logic [63:0] io_req_mask
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence ld_issue(io);
        iss_valid[0] && !iss_store[0] && !iss_stall && dtb_pa[43] == io;
    endsequence
    hit_load_a: assert property (ld_issue(1'b0) ##0 dc_hit[0] |=> reg_wr_valid[0])
        else $error("hit load not written");
    io_load_quiet_a: assert property (
        ld_issue(1'b1) |=> !reg_wr_valid[0] && !maf_req_valid[0]) else $error("io load early");
    wr_cause_a: assert property (reg_wr_valid[0] |-> $past(iss_valid[0] && !iss_store[0]))
        else $error("write without load");
    fill_done_a: assert property (ld_done != 8'h00 |-> $past(fill_valid))
        else $error("done without fill");
    drain_order_a: assert property (dc_wr_valid != 2'h2)
        else $error("younger drained alone");
    req_hold_a: assert property (
        io_req_valid && !io_req_ready |=> io_req_valid && $stable(io_req_mask))
        else $error("request dropped");
    wire half32 = io_req_mask[63:32] == 32'h0 || io_req_mask[31:0] == 32'h0;
    lw_span_a: assert property (io_req_valid && io_req_size == 2'h2 |-> half32)
        else $error("longword span");
    qw_limit_a: assert property (
        io_req_valid && io_req_size == 2'h3 && io_merge_32b_limit |-> half32)
        else $error("quadword span");
endmodule // lsu_io_merge_sva

bind lsu_io_merge lsu_io_merge_sva i_lsu_io_merge_sva (.*);

// File: verif/io_offchip_sink.sv
// Offchip port model that can hold off requests
`timescale 1ns/1ps
module io_offchip_sink (
    // Clock and reset
    input  logic clk,
    input  logic rst,
    // Handshake
    input  logic hold_off,
    output logic io_req_ready
);
    // Ready moves only after an edge
    always @(posedge clk) begin
        io_req_ready <= !rst && !hold_off;
    end
endmodule // io_offchip_sink

// File: verif/test_lsu_io_merge.sv
// Self-checking bench for the load/store unit
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("FAIL %s exp %h got %h", nm, e, g); end end
module test_lsu_io_merge;
    logic         clk, rst, ld_retire, st_retire, memory_barrier, write_barrier, hold_off;
    logic         io_merge_32b_limit, fill_valid, own_valid, iss_stall, io_req_valid;
    logic         io_req_ready, io_req_store;
    logic [1:0]   iss_valid, iss_store, dc_hit, dc_dirty, dc_shared, reg_wr_valid;
    logic [1:0]   maf_req_valid, maf_req_upgrade, dc_wr_valid, io_req_size;
    logic [3:0]   iss_size;
    logic [13:0]  iss_dest;
    logic [37:0]  fill_block, own_block, probe_block;
    logic [43:0]  io_req_addr;
    logic [63:0]  io_req_mask;
    logic [75:0]  maf_req_block;
    logic [87:0]  dtb_pa, dc_wr_pa;
    logic [95:0]  iss_va;
    logic [127:0] iss_data, dc_rdata, reg_wr_data;
    logic [7:0]   ld_done;
    int           n_fail, n_checks;

    lsu_io_merge #(.IDLE_CYCLES(16)) i_lsu_io_merge (.*, .reg_wr_dest(), .ld_done_dest(),
        .dc_wr_size(), .dc_wr_data(), .probe_locked(), .io_req_data());
    io_offchip_sink i_io_offchip_sink (.*);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Slot 1 sits one quadword above slot 0
    task automatic issue(input logic [1:0] v, st, hit, input logic [3:0] sz,
                         input logic [43:0] pa, input logic [63:0] d);
        @(negedge clk);
        {iss_valid, iss_store, dc_hit, iss_size} = {v, st, hit, sz};
        dtb_pa = {pa + 44'h8, pa};
        iss_va = {4'h0, pa + 44'h8, 4'h0, pa};
        {iss_data, dc_rdata} = {d, d, d, d};
        @(negedge clk);
        iss_valid = 2'h0;
    endtask

    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask

    task automatic get_req(input logic st, input logic [63:0] m);
        for (int i = 0; i < 200 && !(io_req_valid && io_req_ready); i++) @(negedge clk);
        `CHK("req_store", st, io_req_store)
        `CHK("req_mask", m, io_req_mask)
        @(negedge clk);
    endtask

    task automatic t_mem;
        issue(2'h3, 2'h0, 2'h3, 4'ha, 44'h1040, 64'h8765_4321_1234_5678);
        `CHK("wr_valid", 2'h3, reg_wr_valid)
        `CHK("wr_data", {2{64'h1234_5678}}, reg_wr_data)
        issue(2'h3, 2'h0, 2'h0, 4'hf, 44'h2000, 64'h0);
        `CHK("maf_valid", 2'h1, maf_req_valid)
        `CHK("maf_block", 38'h80, maf_req_block[37:0])
        fill_block = 38'h80;
        pulse(fill_valid);
        `CHK("done", 2, $countones(ld_done))
        repeat (4) pulse(ld_retire);
        issue(2'h1, 2'h1, 2'h1, 4'h3, 44'h3000, 64'h55);
        `CHK("upgrade", 2'h1, maf_req_valid & maf_req_upgrade)
        own_block = 38'hc0;
        pulse(own_valid);
        pulse(st_retire);
        for (int i = 0; i < 4 && dc_wr_valid === 2'h0; i++) @(negedge clk);
        `CHK("drain", 2'h1, dc_wr_valid)
        `CHK("drain_pa", 44'h3000, dc_wr_pa[43:0])
    endtask

    task automatic t_io;
        {io_merge_32b_limit, hold_off} = 2'h3;
        issue(2'h1, 2'h1, 2'h0, 4'h3, 44'h800_0000_0000, 64'h11);
        issue(2'h1, 2'h1, 2'h0, 4'h3, 44'h800_0000_0008, 64'h22);
        issue(2'h1, 2'h1, 2'h0, 4'h3, 44'h800_0000_0020, 64'h33);
        issue(2'h1, 2'h0, 2'h1, 4'h3, 44'h0, 64'h77);
        `CHK("no_fwd", 64'h77, reg_wr_data[63:0])
        repeat (3) pulse(st_retire);
        pulse(ld_retire);
        pulse(write_barrier);
        repeat (8) @(negedge clk);
        hold_off = 1'b0;
        get_req(1'b1, 64'hffff);
        get_req(1'b1, 64'hff_0000_0000);
        io_merge_32b_limit = 1'b0;
        issue(2'h1, 2'h0, 2'h0, 4'h2, 44'h800_0000_0100, 64'h0);
        `CHK("io_ld_quiet", 2'h0, reg_wr_valid | maf_req_valid)
        issue(2'h1, 2'h0, 2'h0, 4'h2, 44'h800_0000_0108, 64'h0);
        repeat (2) pulse(ld_retire);
        get_req(1'b0, 64'hf0f);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        {iss_valid, iss_store, dc_hit, dc_dirty, dc_shared, iss_size, iss_dest} = '0;
        {ld_retire, st_retire, memory_barrier, write_barrier, hold_off} = '0;
        {io_merge_32b_limit, fill_valid, own_valid, fill_block, own_block} = '0;
        {probe_block, dtb_pa, iss_va, iss_data, dc_rdata} = '0;
        {n_fail, n_checks} = '0;
        rst = 1'b1;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        t_mem;
        t_io;
        print_verdict;
    end

    initial begin
        #100000;
        n_fail++;
        print_verdict;
    end
endmodule // test_lsu_io_merge
